// *** inc/csc_params.svh ***
`ifndef CSC_PARAMS_SVH
`define CSC_PARAMS_SVH

`define CSC_ADDR_WRITE     8'hd2
`define CSC_ADDR_READ      8'hd3
`define CSC_READ_COUNT     8'h08

`define CSC_OFS_SPREAD     8'h00
`define CSC_OFS_GATE_LOW   8'h01
`define CSC_OFS_SPARE_TWO  8'h02
`define CSC_OFS_GATE_HIGH  8'h03
`define CSC_OFS_SPARE_FOUR 8'h04
`define CSC_OFS_SWING      8'h05
`define CSC_OFS_SPARE_SIX  8'h06
`define CSC_OFS_IDENT      8'h07

`define CSC_BIT_SPREAD     5
`define CSC_BIT_OUT0_GATE  6
`define CSC_BIT_OUT1_GATE  3
`define CSC_BIT_OUT5_GATE  7
`define CSC_BIT_OUT4_GATE  6
`define CSC_MSB_SWING_UP   7
`define CSC_LSB_SWING_UP   6
`define CSC_MSB_SWING_MID  5
`define CSC_LSB_SWING_MID  4
`define CSC_MSB_SWING_OUT0 1
`define CSC_LSB_SWING_OUT0 0

`define CSC_RST_SPREAD     1'b1
`define CSC_RST_GATE       1'b1
`define CSC_RST_SWING_UP   2'h0
`define CSC_RST_SWING_MID  2'h0
`define CSC_RST_SWING_OUT0 2'h1

// Identification nibbles: arbitrary values
`define CSC_REV_CODE       4'h3
`define CSC_MAKER_CODE     4'h5

`endif

// *** inc/csc_pkg.sv ***
package csc_pkg;

  typedef struct packed {
    logic       spreadOn;
    logic       out5Gate;
    logic       out4Gate;
    logic       out1Gate;
    logic       out0Gate;
    logic [1:0] swingSelUpperGroup;
    logic [1:0] swingSelMiddleGroup;
    logic [1:0] swingSelOut0;
  } csc_cfg_t;

  typedef struct packed {
    logic [5:0] diffTrue;
    logic [5:0] diffComp;
  } csc_diff_t;

  typedef enum logic [2:0] {
    CSC_IDLE  = 3'h0,
    CSC_ADDR  = 3'h1,
    CSC_INDEX = 3'h3,
    CSC_COUNT = 3'h2,
    CSC_WDATA = 3'h6,
    CSC_RDATA = 3'h7
  } csc_state_t;

endpackage

// *** core/csc_regs.sv ***
`include "csc_params.svh"

// Behaviour
// - Byte 0 bit 5 read/write spread enable, 1 gives down-spread, reset 1
// - Byte 1 bit 6 read/write enable of output 0, reset 1
// - Byte 1 bit 3 read/write enable of output 1, reset 1
// - Byte 3 bit 7 read/write enable of output 5, reset 1
// - Byte 3 bit 6 read/write enable of output 4, reset 1
// - Byte 5 bits 7:6 swing code of upper group, 700 to 1000 mV
// - Byte 5 bits 5:4 swing code of outputs 1 to 3
// - Byte 5 bits 1:0 swing code of output 0, reset 01 (800 mV)
// - Byte 7 read-only: revision nibble high, maker nibble low
// - Bytes 2, 4, 6 and unassigned bits are reserved, read as 0
// - Disabled output drives both legs low, enabled output toggles
// - Write: address, index, count, data bytes stored at rising index
// - Read: index write, restart, count byte then successive bytes
// - Bus address D2 hex for writes, D3 hex for reads
module csc_regs
  import csc_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       srst,
  input  wire logic       smbClk,
  input  wire logic       smbDatIn,
  output logic            smbDatOut,
  output logic            smbDatOe,
  output csc_cfg_t        cfgOut,
  output csc_diff_t       diffClockOut
);

  localparam csc_cfg_t CFG_RESET = '{
    spreadOn:            `CSC_RST_SPREAD,
    out5Gate:            `CSC_RST_GATE,
    out4Gate:            `CSC_RST_GATE,
    out1Gate:            `CSC_RST_GATE,
    out0Gate:            `CSC_RST_GATE,
    swingSelUpperGroup:  `CSC_RST_SWING_UP,
    swingSelMiddleGroup: `CSC_RST_SWING_MID,
    swingSelOut0:        `CSC_RST_SWING_OUT0
  };

  // Register image of one byte index
  function automatic logic [7:0] readByte(
    input logic [7:0] idx,
    input csc_cfg_t   cfg
  );
    logic [7:0] b;
    b = 8'h00;
    unique case (idx)
      `CSC_OFS_SPREAD:
        b[`CSC_BIT_SPREAD] = cfg.spreadOn;
      `CSC_OFS_GATE_LOW:
      begin
        b[`CSC_BIT_OUT0_GATE] = cfg.out0Gate;
        b[`CSC_BIT_OUT1_GATE] = cfg.out1Gate;
      end
      `CSC_OFS_GATE_HIGH:
      begin
        b[`CSC_BIT_OUT5_GATE] = cfg.out5Gate;
        b[`CSC_BIT_OUT4_GATE] = cfg.out4Gate;
      end
      `CSC_OFS_SWING:
      begin
        b[`CSC_MSB_SWING_UP:`CSC_LSB_SWING_UP] =
          cfg.swingSelUpperGroup;
        b[`CSC_MSB_SWING_MID:`CSC_LSB_SWING_MID] =
          cfg.swingSelMiddleGroup;
        b[`CSC_MSB_SWING_OUT0:`CSC_LSB_SWING_OUT0] =
          cfg.swingSelOut0;
      end
      `CSC_OFS_IDENT:
        b = {`CSC_REV_CODE, `CSC_MAKER_CODE};
      default:
        b = 8'h00;
    endcase
    return b;
  endfunction

  // Configuration after a byte write at one index
  function automatic csc_cfg_t writeByte(
    input logic [7:0] idx,
    input logic [7:0] d,
    input csc_cfg_t   cfg
  );
    csc_cfg_t c;
    c = cfg;
    unique case (idx)
      `CSC_OFS_SPREAD:
        c.spreadOn = d[`CSC_BIT_SPREAD];
      `CSC_OFS_GATE_LOW:
      begin
        c.out0Gate = d[`CSC_BIT_OUT0_GATE];
        c.out1Gate = d[`CSC_BIT_OUT1_GATE];
      end
      `CSC_OFS_GATE_HIGH:
      begin
        c.out5Gate = d[`CSC_BIT_OUT5_GATE];
        c.out4Gate = d[`CSC_BIT_OUT4_GATE];
      end
      `CSC_OFS_SWING:
      begin
        c.swingSelUpperGroup =
          d[`CSC_MSB_SWING_UP:`CSC_LSB_SWING_UP];
        c.swingSelMiddleGroup =
          d[`CSC_MSB_SWING_MID:`CSC_LSB_SWING_MID];
        c.swingSelOut0 =
          d[`CSC_MSB_SWING_OUT0:`CSC_LSB_SWING_OUT0];
      end
      default:
        c = cfg;
    endcase
    return c;
  endfunction

  // Pin synchronisers and edge history
  logic [1:0] sclSync_reg;
  logic [1:0] sdaSync_reg;
  logic       sclLast_reg;
  logic       sdaLast_reg;

  csc_state_t state_reg;
  csc_state_t state_next;
  logic [3:0] bitCnt_reg;
  logic [3:0] bitCnt_next;
  logic [7:0] rxShift_reg;
  logic [7:0] rxShift_next;
  logic [7:0] txShift_reg;
  logic [7:0] txShift_next;
  logic [7:0] index_reg;
  logic [7:0] index_next;
  logic [7:0] remain_reg;
  logic [7:0] remain_next;
  logic       ackOk_reg;
  logic       ackOk_next;
  logic       masterAck_reg;
  logic       masterAck_next;
  logic       oe_next;
  csc_cfg_t   cfg_reg;
  csc_cfg_t   cfg_next;
  logic       phase_reg;

  wire logic scl      = sclSync_reg[1];
  wire logic sda      = sdaSync_reg[1];
  wire logic sclRise  = scl & ~sclLast_reg;
  wire logic sclFall  = ~scl & sclLast_reg;
  wire logic startSeen = scl & sclLast_reg & ~sda & sdaLast_reg;
  wire logic stopSeen  = scl & sclLast_reg & sda & ~sdaLast_reg;
  wire logic lastData = (bitCnt_reg == 4'h7);
  wire logic ackSlot  = (bitCnt_reg == 4'h8);
  wire logic [7:0] rxByte = rxShift_reg;
  wire logic [7:0] curByte = readByte(index_reg, cfg_reg);
  wire logic addrWrite = (rxByte == `CSC_ADDR_WRITE);
  wire logic addrRead  = (rxByte == `CSC_ADDR_READ);
  wire logic isRead    = (state_reg == CSC_RDATA);

  always_comb
  begin
    state_next     = state_reg;
    bitCnt_next    = bitCnt_reg;
    rxShift_next   = rxShift_reg;
    txShift_next   = txShift_reg;
    index_next     = index_reg;
    remain_next    = remain_reg;
    ackOk_next     = ackOk_reg;
    masterAck_next = masterAck_reg;
    cfg_next       = cfg_reg;
    oe_next        = smbDatOe;
    if (stopSeen)
    begin
      state_next = CSC_IDLE;
      oe_next    = 1'b0;
    end
    else if (startSeen)
    begin
      // Start or repeated start: a new address byte follows; the
      // start's own clock fall wraps the count to zero
      state_next  = CSC_ADDR;
      bitCnt_next = 4'hf;
      oe_next     = 1'b0;
    end
    else if (state_reg != CSC_IDLE)
    begin
      if (sclRise)
      begin
        if (!ackSlot)
          rxShift_next = {rxShift_reg[6:0], sda};
        else if (isRead)
          masterAck_next = ~sda;
      end
      else if (sclFall)
      begin
        if (lastData)
        begin
          bitCnt_next = 4'h8;
          ackOk_next  = 1'b1;
          unique case (state_reg)
            CSC_ADDR:
              ackOk_next = addrWrite | addrRead;
            CSC_INDEX:
              index_next = rxByte;
            CSC_COUNT:
              remain_next = rxByte;
            CSC_WDATA:
            begin
              if (remain_reg != 8'h00)
              begin
                cfg_next    = writeByte(index_reg, rxByte, cfg_reg);
                index_next  = index_reg + 8'h01;
                remain_next = remain_reg - 8'h01;
              end
            end
            default:
              ackOk_next = 1'b0;
          endcase
          // Receiver acks by pulling low; transmitter releases
          oe_next = isRead ? 1'b0 : (state_reg == CSC_ADDR ?
            (addrWrite | addrRead) : 1'b1);
        end
        else if (ackSlot)
        begin
          bitCnt_next = 4'h0;
          oe_next     = 1'b0;
          unique case (state_reg)
            CSC_ADDR:
            begin
              if (!ackOk_reg)
                state_next = CSC_IDLE;
              else if (rxByte[0])
              begin
                // Byte count goes out ahead of the data
                state_next   = CSC_RDATA;
                txShift_next = `CSC_READ_COUNT;
                oe_next      = ~txShift_next[7];
              end
              else
                state_next = CSC_INDEX;
            end
            CSC_INDEX:
              state_next = CSC_COUNT;
            CSC_COUNT:
              state_next = CSC_WDATA;
            CSC_WDATA:
              state_next = CSC_WDATA;
            CSC_RDATA:
            begin
              if (masterAck_reg)
              begin
                txShift_next = curByte;
                index_next   = index_reg + 8'h01;
                oe_next      = ~txShift_next[7];
              end
              else
                state_next = CSC_IDLE;
            end
            default:
              state_next = CSC_IDLE;
          endcase
        end
        else
        begin
          bitCnt_next = bitCnt_reg + 4'h1;
          if (isRead)
          begin
            txShift_next = {txShift_reg[6:0], 1'b0};
            oe_next      = ~txShift_next[7];
          end
        end
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    sclSync_reg <= {sclSync_reg[0], smbClk};
    sdaSync_reg <= {sdaSync_reg[0], smbDatIn};
    sclLast_reg <= sclSync_reg[1];
    sdaLast_reg <= sdaSync_reg[1];
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      state_reg     <= CSC_IDLE;
      bitCnt_reg    <= 4'h0;
      rxShift_reg   <= 8'h00;
      txShift_reg   <= 8'h00;
      index_reg     <= 8'h00;
      remain_reg    <= 8'h00;
      ackOk_reg     <= 1'b0;
      masterAck_reg <= 1'b0;
      cfg_reg       <= CFG_RESET;
      smbDatOe      <= 1'b0;
    end
    else
    begin
      state_reg     <= state_next;
      bitCnt_reg    <= bitCnt_next;
      rxShift_reg   <= rxShift_next;
      txShift_reg   <= txShift_next;
      index_reg     <= index_next;
      remain_reg    <= remain_next;
      ackOk_reg     <= ackOk_next;
      masterAck_reg <= masterAck_next;
      cfg_reg       <= cfg_next;
      smbDatOe      <= oe_next;
    end
  end

  // Outputs 2 and 3 have their gates outside this bank and stay running
  wire logic [5:0] gates = {cfg_reg.out5Gate, cfg_reg.out4Gate,
                            2'b11, cfg_reg.out1Gate, cfg_reg.out0Gate};

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      phase_reg    <= 1'b0;
      diffClockOut <= '0;
      cfgOut       <= CFG_RESET;
      smbDatOut    <= 1'b0;
    end
    else
    begin
      phase_reg             <= ~phase_reg;
      diffClockOut.diffTrue <= gates & {6{phase_reg}};
      diffClockOut.diffComp <= gates & {6{~phase_reg}};
      cfgOut                <= cfg_reg;
      smbDatOut             <= 1'b0;
    end
  end

endmodule

// *** dv/csc_regs_checker.sv ***
module csc_regs_checker
  import csc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic smbClk,
  input wire logic smbDatIn,
  input wire logic smbDatOut,
  input wire logic smbDatOe,
  input csc_cfg_t  cfgOut,
  input csc_diff_t diffClockOut
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic [2:0] upCnt;
  wire  [5:0] gate = {cfgOut.out5Gate, cfgOut.out4Gate, 2'h3,
                      cfgOut.out1Gate, cfgOut.out0Gate};
  wire  [5:0] legT = diffClockOut.diffTrue;
  wire  [5:0] legC = diffClockOut.diffComp;
  always_ff @(posedge ref_clk)
    if (srst) upCnt <= 3'h0;
    else if (upCnt != 3'h7) upCnt <= upCnt + 3'h1;
  property p_cfg_rst;
    $fell(srst) |-> cfgOut == 11'h7c1;
  endproperty
  a_cfg_rst: assert property (p_cfg_rst)
    else $error("cfg not default after reset");
  property p_diff_rst;
    $fell(srst) |-> (legT | legC) == 6'h0;
  endproperty
  a_diff_rst: assert property (p_diff_rst)
    else $error("pairs not low after reset");
  property p_off;
    upCnt == 3'h7 |-> ((legT | legC) & ~gate & ~$past(gate)
                        & ~$past(gate, 2)) == 6'h0;
  endproperty
  a_off: assert property (p_off)
    else $error("disabled pair not low");
  property p_on;
    upCnt == 3'h7 |-> ((~(legT ^ $past(legT)) | ~(legT ^ legC))
                        & gate & $past(gate) & $past(gate, 2)) == 6'h0;
  endproperty
  a_on: assert property (p_on)
    else $error("enabled pair not toggling");
  property p_drv;
    smbDatOut == 1'b0;
  endproperty
  a_drv: assert property (p_drv)
    else $error("data pin driven high");
  property p_ack_low;
    $rose(smbDatOe) |-> !smbClk;
  endproperty
  a_ack_low: assert property (p_ack_low)
    else $error("data drive began with clock high");
  property p_oe_hold;
    smbClk && $past(smbClk) |-> $stable(smbDatOe);
  endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("data drive moved with clock high");
  property p_oe_len;
    $rose(smbDatOe) |-> smbDatOe [*4];
  endproperty
  a_oe_len: assert property (p_oe_len)
    else $error("data drive too short");
  property p_cfg_low;
    $changed(cfgOut) |-> !smbClk;
  endproperty
  a_cfg_low: assert property (p_cfg_low)
    else $error("cfg changed with clock high");
endmodule

bind csc_regs csc_regs_checker u_chk (.ref_clk(ref_clk), .srst(srst),
  .smbClk(smbClk), .smbDatIn(smbDatIn), .smbDatOut(smbDatOut),
  .smbDatOe(smbDatOe), .cfgOut(cfgOut), .diffClockOut(diffClockOut));

// *** dv/csc_host.sv ***
module csc_host
(
  input  wire logic ref_clk,
  input  wire logic smbDat,
  output logic      smbClk,
  output logic      datHost
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    smbClk = 1'b1;
    datHost = 1'b1;
  end
  // Quarter bit of 10 cycles: quick, yet far above the sync latency
  task q;
    repeat (10) @(posedge ref_clk);
    #1;
  endtask
  task bitx(input logic b, output logic r);
    datHost = b;
    q();
    smbClk = 1'b1;
    q();
    r = smbDat;
    q();
    smbClk = 1'b0;
    q();
  endtask
  task start;
    datHost = 1'b1;
    q();
    smbClk = 1'b1;
    q();
    datHost = 1'b0;
    q();
    smbClk = 1'b0;
    q();
  endtask
  task stop;
    datHost = 1'b0;
    q();
    smbClk = 1'b1;
    q();
    datHost = 1'b1;
    q();
  endtask
  task wb(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bitx(v[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask
  task rb(input logic last, output logic [7:0] v);
    logic r;
    for (int i = 0; i < 8; i++)
    begin
      bitx(1'b1, r);
      v = {v[6:0], r};
    end
    bitx(last, r);
  endtask
endmodule

// *** dv/csc_regs_bench.sv ***
module csc_regs_bench import csc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic       ref_clk;
  logic       srst;
  logic       smbClk;
  logic       datHost;
  logic       smbDatOut;
  logic       smbDatOe;
  csc_cfg_t   cfgOut;
  csc_diff_t  diffClockOut;
  wire        smbDat = datHost & ~smbDatOe;
  int         num_errors = 0;
  int         n_tests = 0;
  logic [7:0] sh [0:7] = '{8'h20, 8'h48, 8'h00, 8'hc0, 8'h00, 8'h01,
                           8'h00, 8'h35};
  localparam logic [7:0] M [0:7] = '{8'h20, 8'h48, 8'h00, 8'hc0, 8'h00,
                                     8'hf3, 8'h00, 8'h00};
  csc_regs u_dut (.ref_clk(ref_clk), .srst(srst), .smbClk(smbClk),
    .smbDatIn(smbDat), .smbDatOut(smbDatOut), .smbDatOe(smbDatOe),
    .cfgOut(cfgOut), .diffClockOut(diffClockOut));
  csc_host u_host (.ref_clk(ref_clk), .smbDat(smbDat), .smbClk(smbClk),
    .datHost(datHost));
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  function automatic csc_cfg_t cf();
    return {sh[0][5], sh[3][7], sh[3][6], sh[1][3], sh[1][6],
            sh[5][7:6], sh[5][5:4], sh[5][1:0]};
  endfunction
  function automatic logic [7:0] rdv(int i);
    return i < 8 ? sh[i] : 8'h00;
  endfunction
  task chk(input string nm, input logic [15:0] got, input logic [15:0] ex);
    n_tests++;
    if (got !== ex)
    begin
      num_errors++;
      $display("mismatch %s exp %h got %h", nm, ex, got);
    end
  endtask
  task wr(input logic [7:0] a, ix, cnt, input int n);
    logic       ack;
    logic [7:0] d;
    u_host.start();
    u_host.wb(a, ack);
    chk("addr ack", 16'(ack), 16'(a == 8'hd2));
    if (ack)
    begin
      u_host.wb(ix, ack);
      u_host.wb(cnt, ack);
      for (int k = 0; k < n; k++)
      begin
        d = 8'($urandom);
        u_host.wb(d, ack);
        chk("data ack", 16'(ack), 16'h1);
        if (k < cnt && ix + k < 8)
          sh[ix+k] = (sh[ix+k] & ~M[ix+k]) | (d & M[ix+k]);
      end
    end
    u_host.stop();
    chk("cfg", 16'(cfgOut), 16'(cf()));
  endtask
  task rd(input logic [7:0] ix, input int n);
    logic       ack;
    logic [7:0] v;
    u_host.start();
    u_host.wb(8'hd2, ack);
    u_host.wb(ix, ack);
    u_host.start();
    u_host.wb(8'hd3, ack);
    chk("read ack", 16'(ack), 16'h1);
    u_host.rb(1'b0, v);
    chk("count", 16'(v), 16'h8);
    for (int k = 0; k < n; k++)
    begin
      u_host.rb(k == n - 1, v);
      chk("byte", 16'(v), 16'(rdv(ix + k)));
    end
    u_host.stop();
  endtask
  task results;
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (90000) @(posedge ref_clk);
    num_errors++;
    results();
  end
  initial
  begin
    srst = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 srst = 1'b0;
    void'($urandom(63));
    repeat (4) @(posedge ref_clk);
    #1;
    chk("cfg reset", 16'(cfgOut), 16'h07c1);
    rd(8'h00, 8);
    wr(8'ha4, 8'h01, 8'h01, 1);
    wr(8'hd2, 8'h01, 8'h01, 2);
    repeat (6)
    begin
      wr(8'hd2, 8'($urandom_range(7)), 8'($urandom_range(4, 1)), 4);
      rd(8'($urandom_range(7)), 4);
    end
    wr(8'hd2, 8'h05, 8'h03, 3);
    rd(8'h00, 9);
    results();
  end
endmodule
